// [core/raf_rx_filter.v]
// receive start/stop control, descriptor ownership check and address filter
//
// Summary of operation
// - inverse flag with perfect filtering inverts the address match outcome
// - inverse, hash-only and hash/perfect flags are read-only, loaded by setup frame
// - pass-bad-frames delivers errored, runt and truncated frames into buffers
// - hash-only flag applies hash filtering to multicast and physical addresses
// - frames reach the receive FIFO only if receive-start is set at their first byte
// - start from stopped enters running and checks the current descriptor
// - host-owned descriptor suspends reception and sets buffer-unavailable status
// - clearing start finishes current frame and pending work, then stops
// - hash/perfect clear means perfect filtering against setup-frame addresses
// - hash/perfect set hashes multicast; physical per hash-only flag
// - all flags clear means perfect filtering against sixteen addresses
// - hash/perfect only: one physical address, multicast through 512-bit hash
// - hash-only and hash/perfect: every address through the 512-bit hash
// - promiscuous accepts every full-length frame and overrides all other filtering
// - pass-all-multicast accepts any multicast destination regardless of check
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`include "raf_rx_filter_defs.vh"

module raf_rx_filter #(
   parameter NUM_ADDR  = 16,
   parameter HASH_BITS = 512
) (
   input  wire        clk_sys,
   input  wire        sys_rst,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   output reg         irq,
   // setup frame contents
   input  wire        setupTypeWe,
   input  wire [1:0]  setupFilterType,
   input  wire        setupAddrWe,
   input  wire [3:0]  setupAddrIdx,
   input  wire [47:0] setupAddr,
   input  wire        setupHashWe,
   input  wire [4:0]  setupHashIdx,
   input  wire [15:0] setupHashWord,
   // descriptor ownership check
   output reg         descReq,
   input  wire        descAck,
   input  wire        descOwn,
   // network side byte stream
   input  wire        rxValid,
   input  wire        rxSof,
   input  wire        rxEof,
   input  wire [7:0]  rxData,
   input  wire        rxErr,
   // receive fifo write side
   output reg         fifoValid,
   output reg         fifoSof,
   output reg         fifoEof,
   output reg         fifoBad,
   output reg  [7:0]  fifoData
);

   localparam DEPTH = 6;

   ////////////////////////////////////////////////////////////////////////////////
   // registers and storage
   reg  [7:0]          opMode;
   reg  [1:0]          rxState;
   reg  [2:0]          evtStatus;
   reg  [2:0]          intEn;
   reg                 descOk;
   reg                 dataPhase;
   reg  [7:0]          dpAddr;
   reg                 dpWrite;
   reg  [47:0]         addrTable [0:NUM_ADDR-1];
   reg  [HASH_BITS-1:0] hashTable;
   reg  [2:0]          byteIdx;
   reg  [39:0]         daReg;
   reg  [31:0]         crcReg;
   reg                 inFrame;
   reg                 frameGo;
   reg                 frameErr;
   reg                 frameAccept;
   reg  [7:0]          pipeData [0:DEPTH-1];
   reg  [DEPTH-1:0]    pipeValid;
   reg  [DEPTH-1:0]    pipeSof;
   reg  [DEPTH-1:0]    pipeEof;
   reg  [DEPTH-1:0]    pipeErr;
   integer             k, j;

   // crc-32 over one byte, lsb first; low bits select the hash entry
   function [31:0] crc_byte;
      input [31:0] crcIn;
      input [7:0]  dataIn;
      integer      b;
      reg   [31:0] c;
      begin
         c = crcIn;
         for (b = 0; b < 8; b = b + 1) begin
            if (c[0] ^ dataIn[b])
               c = (c >> 1) ^ 32'hEDB8_8320;
            else
               c = c >> 1;
         end
         crc_byte = c;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // address decision
   wire        hashPerfect = opMode[`RAF_OM_HASH_PERFECT];
   wire        hashOnly    = opMode[`RAF_OM_HASH_ONLY];
   wire        inverse     = opMode[`RAF_OM_INVERSE];
   wire        passBad     = opMode[`RAF_OM_PASS_BAD];
   wire        promisc     = opMode[`RAF_OM_PROMISC];
   wire        passMcast   = opMode[`RAF_OM_PASS_MCAST];
   wire        startCmd    = opMode[`RAF_OM_RX_START];
   wire [2:0]  curIdx      = rxSof ? 3'h0 : byteIdx;
   wire [47:0] fullDa      = {rxData, daReg};
   wire [31:0] crcSeed     = rxSof ? 32'hFFFF_FFFF : crcReg;
   wire [31:0] crcNext     = crc_byte(crcSeed, rxData);
   wire [8:0]  hashIdx     = crcNext[8:0];
   wire        hashHit     = hashTable[hashIdx];
   wire        isMcast     = daReg[0];
   wire [NUM_ADDR-1:0] addrHit;

   // one comparator per stored physical address
   genvar g;
   generate
      for (g = 0; g < NUM_ADDR; g = g + 1) begin : gen_cmp
         assign addrHit[g] = (addrTable[g] == fullDa);
      end
   endgenerate

   reg matchRaw;
   reg filterPass;
   always @* begin
      if (!hashPerfect) begin
         matchRaw = |addrHit ^ inverse;
      end else if (hashOnly) begin
         matchRaw = hashHit;
      end else if (isMcast) begin
         matchRaw = hashHit;
      end else begin
         matchRaw = addrHit[0];
      end
      // overrides first, otherwise the filter verdict alone
      filterPass = promisc | (passMcast & isMcast) | matchRaw;
   end

   // a frame may only start when started, running and holding an owned descriptor
   wire eligible   = startCmd & (rxState == `RAF_STATE_RUNNING) & descOk & ~descReq;
   wire goNow      = rxSof ? eligible : frameGo;
   wire decideFull = rxValid & (curIdx == `RAF_DA_LAST);
   wire decideRunt = rxValid & rxEof & (curIdx < `RAF_DA_LAST);
   wire acceptFull = goNow & filterPass;
   wire acceptRunt = goNow & passBad;
   wire acceptNow  = decideFull ? acceptFull : (decideRunt ? acceptRunt : frameAccept);
   wire pipeBusy   = |pipeValid;

   ////////////////////////////////////////////////////////////////////////////////
   // input side: destination capture and frame verdict
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         byteIdx     <= 3'h0;
         daReg       <= 40'h00_0000_0000;
         crcReg      <= 32'hFFFF_FFFF;
         inFrame     <= 1'b0;
         frameGo     <= 1'b0;
         frameErr    <= 1'b0;
         frameAccept <= 1'b0;
      end else if (rxValid) begin
         inFrame <= ~rxEof;
         frameGo <= goNow;
         frameErr <= rxEof ? 1'b0 : ((rxSof ? 1'b0 : frameErr) | rxErr);
         if (curIdx < `RAF_DA_BYTES) begin
            byteIdx <= curIdx + 3'h1;
            crcReg  <= crcNext;
         end
         if (curIdx < `RAF_DA_LAST)
            daReg[curIdx*8 +: 8] <= rxData;
         if (decideFull)
            frameAccept <= acceptFull;
         else if (decideRunt)
            frameAccept <= acceptRunt;
      end
   end

   // fixed delay line so the verdict is known before the first byte leaves
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pipeValid <= {DEPTH{1'b0}};
         pipeSof   <= {DEPTH{1'b0}};
         pipeEof   <= {DEPTH{1'b0}};
         pipeErr   <= {DEPTH{1'b0}};
         for (k = 0; k < DEPTH; k = k + 1)
            pipeData[k] <= 8'h00;
      end else begin
         pipeValid <= {pipeValid[DEPTH-2:0], rxValid};
         pipeSof   <= {pipeSof[DEPTH-2:0], rxValid & rxSof};
         pipeEof   <= {pipeEof[DEPTH-2:0], rxValid & rxEof};
         pipeErr   <= {pipeErr[DEPTH-2:0], rxErr | (~rxSof & frameErr)};
         pipeData[0] <= rxData;
         for (k = 1; k < DEPTH; k = k + 1)
            pipeData[k] <= pipeData[k-1];
      end
   end

   // fifo write: dropped frames never appear; errored ones are marked unless passed
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         fifoValid <= 1'b0;
         fifoSof   <= 1'b0;
         fifoEof   <= 1'b0;
         fifoBad   <= 1'b0;
         fifoData  <= 8'h00;
      end else begin
         fifoValid <= pipeValid[DEPTH-1] & frameAccept;
         fifoSof   <= pipeValid[DEPTH-1] & frameAccept & pipeSof[DEPTH-1];
         fifoEof   <= pipeValid[DEPTH-1] & frameAccept & pipeEof[DEPTH-1];
         fifoBad   <= pipeValid[DEPTH-1] & frameAccept & pipeEof[DEPTH-1]
                      & pipeErr[DEPTH-1] & ~passBad;
         fifoData  <= pipeData[DEPTH-1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // setup frame tables and read-only filter flags
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         hashTable <= {HASH_BITS{1'b0}};
         for (j = 0; j < NUM_ADDR; j = j + 1)
            addrTable[j] <= 48'h0000_0000_0000;
      end else begin
         if (setupAddrWe)
            addrTable[setupAddrIdx] <= setupAddr;
         if (setupHashWe)
            hashTable[setupHashIdx*16 +: 16] <= setupHashWord;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait states, always okay
   wire addrPhase = hsel & htrans[1] & hready;
   wire wrOpMode  = dataPhase & dpWrite & (dpAddr == `RAF_OFS_OPMODE);
   wire wrIntClr  = dataPhase & dpWrite & (dpAddr == `RAF_OFS_INTCLR);
   wire wrIntEn   = dataPhase & dpWrite & (dpAddr == `RAF_OFS_INTEN);
   wire wrPoll    = dataPhase & dpWrite & (dpAddr == `RAF_OFS_POLL);

   // status word as software sees it
   wire [31:0] statusWord = {13'h0000, rxState, 8'h00, evtStatus, 6'h00};

   reg [31:0] next_hrdata;
   always @* begin
      if (haddr == `RAF_OFS_OPMODE)
         next_hrdata = {24'h00_0000, opMode};
      else if (haddr == `RAF_OFS_STATUS)
         next_hrdata = statusWord;
      else if (haddr == `RAF_OFS_INTEN)
         next_hrdata = {23'h00_0000, intEn, 6'h00};
      else
         next_hrdata = 32'h0000_0000;                     // unmapped and write-only
   end

   // address phase captured, read data registered for the data phase
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         dataPhase <= 1'b0;
         dpAddr    <= 8'h00;
         dpWrite   <= 1'b0;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dataPhase <= addrPhase;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addrPhase) begin
            dpAddr  <= {haddr[7:2], 2'h0};
            dpWrite <= hwrite;
            hrdata  <= hwrite ? 32'h0000_0000 : next_hrdata;
         end
      end
   end

   // software owns start, pass-bad, promiscuous and pass-multicast; the setup frame
   // alone sets the inverse, hash-only and hash/perfect bits
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         opMode <= `RAF_OPMODE_RST;
      end else begin
         if (wrOpMode) begin
            opMode[`RAF_OM_RX_START]   <= hwdata[`RAF_OM_RX_START];
            opMode[`RAF_OM_PASS_BAD]   <= hwdata[`RAF_OM_PASS_BAD];
            opMode[`RAF_OM_PROMISC]    <= hwdata[`RAF_OM_PROMISC];
            opMode[`RAF_OM_PASS_MCAST] <= hwdata[`RAF_OM_PASS_MCAST];
         end
         if (setupTypeWe) begin
            opMode[`RAF_OM_HASH_PERFECT] <= setupFilterType[0];
            opMode[`RAF_OM_HASH_ONLY]    <= (setupFilterType == `RAF_FT_HASH_ONLY);
            opMode[`RAF_OM_INVERSE]      <= (setupFilterType == `RAF_FT_INVERSE);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // receive process: stopped, running, suspended
   wire rxIdle    = ~inFrame & ~pipeBusy & ~(rxValid & ~rxEof);
   wire evtDone   = pipeValid[DEPTH-1] & frameAccept & pipeEof[DEPTH-1];
   reg  evtUnavail;
   reg  evtStop;
   reg  [1:0] next_rxState;

   always @* begin
      next_rxState = rxState;
      evtUnavail   = 1'b0;
      evtStop      = 1'b0;
      case (rxState)
         `RAF_STATE_STOPPED: begin
            if (startCmd)
               next_rxState = `RAF_STATE_RUNNING;
         end
         `RAF_STATE_RUNNING: begin
            if (!startCmd && rxIdle && !descReq) begin
               next_rxState = `RAF_STATE_STOPPED;
               evtStop      = 1'b1;
            end else if (descReq && descAck && !descOwn) begin
               next_rxState = `RAF_STATE_SUSPENDED;
               evtUnavail   = 1'b1;
            end
         end
         `RAF_STATE_SUSPENDED: begin
            if (!startCmd && rxIdle) begin
               next_rxState = `RAF_STATE_STOPPED;
               evtStop      = 1'b1;
            end else if (wrPoll) begin
               next_rxState = `RAF_STATE_RUNNING;
            end
         end
         default: begin
            next_rxState = `RAF_STATE_STOPPED;
         end
      endcase
   end

   // descriptor check: one request outstanding until acknowledged
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rxState <= `RAF_STATE_STOPPED;
         descReq <= 1'b0;
         descOk  <= 1'b0;
      end else begin
         rxState <= next_rxState;
         if (descReq) begin
            if (descAck) begin
               descReq <= 1'b0;
               descOk  <= descOwn;
            end
         end else if (rxState == `RAF_STATE_RUNNING && startCmd && !descOk) begin
            descReq <= 1'b1;
         end
         // an accepted frame consumes its descriptor as its last byte arrives
         if (rxValid && rxEof && acceptNow)
            descOk <= 1'b0;
         if (next_rxState == `RAF_STATE_STOPPED)
            descOk <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sticky events, write-one-to-clear, enable mask; a new event beats its clear
   wire [2:0] evtSet = {evtStop, evtUnavail, evtDone};
   wire [2:0] clrBits = wrIntClr ? hwdata[`RAF_ST_RX_STOPPED:`RAF_ST_RX_DONE] : 3'h0;

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         evtStatus <= 3'h0;
         intEn     <= `RAF_INTEN_RST;
         irq       <= 1'b0;
      end else begin
         evtStatus <= (evtStatus & ~clrBits) | evtSet;
         if (wrIntEn)
            intEn <= hwdata[`RAF_ST_RX_STOPPED:`RAF_ST_RX_DONE];
         irq <= |(((evtStatus & ~clrBits) | evtSet) & (wrIntEn ?
                  hwdata[`RAF_ST_RX_STOPPED:`RAF_ST_RX_DONE] : intEn));
      end
   end

endmodule

// [core/raf_rx_filter_defs.vh]
// register map, field positions, reset values and state codes of the receive filter
`ifndef RAF_RX_FILTER_DEFS_VH
`define RAF_RX_FILTER_DEFS_VH

// register byte offsets
`define RAF_OFS_OPMODE     8'h00
`define RAF_OFS_STATUS     8'h04
`define RAF_OFS_INTCLR     8'h08
`define RAF_OFS_INTEN      8'h0C
`define RAF_OFS_POLL       8'h10

// operation_mode_control fields
`define RAF_OM_HASH_PERFECT    0
`define RAF_OM_RX_START        1
`define RAF_OM_HASH_ONLY       2
`define RAF_OM_PASS_BAD        3
`define RAF_OM_INVERSE         4
`define RAF_OM_PROMISC         6
`define RAF_OM_PASS_MCAST      7

// status_register fields (sticky events and process state)
`define RAF_ST_RX_DONE         6
`define RAF_ST_BUF_UNAVAIL     7
`define RAF_ST_RX_STOPPED      8
`define RAF_ST_STATE_LO        17
`define RAF_ST_STATE_HI        18
`define RAF_EVT_MASK           32'h0000_01C0

// reset values
`define RAF_OPMODE_RST         8'h00
`define RAF_INTEN_RST          3'h0

// receive process states
`define RAF_STATE_STOPPED      2'h0
`define RAF_STATE_RUNNING      2'h1
`define RAF_STATE_SUSPENDED    2'h2

// setup frame filtering-type codes
`define RAF_FT_PERFECT         2'h0
`define RAF_FT_HASH            2'h1
`define RAF_FT_INVERSE         2'h2
`define RAF_FT_HASH_ONLY       2'h3

// destination address bytes and index of the last one
`define RAF_DA_BYTES           3'h6
`define RAF_DA_LAST            3'h5

`endif

// [dv/raf_rx_filter_checker.sv]
// port-level assertions for the receive filter
module raf_rx_filter_checker (
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic       descReq,
   input wire logic       descAck,
   input wire logic       rxValid,
   input wire logic       rxSof,
   input wire logic       rxEof,
   input wire logic [7:0] rxData,
   input wire logic       fifoValid,
   input wire logic       fifoSof,
   input wire logic       fifoEof,
   input wire logic       fifoBad,
   input wire logic [7:0] fifoData
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // fifo writes must trace back to a byte taken seven edges before
   chk_fifo_cause: assert property (fifoValid |-> $past(rxValid, 7))
      else $error("fifo write without a byte taken");
   chk_data_delay: assert property (fifoValid |-> fifoData == $past(rxData, 7))
      else $error("fifo byte differs from received byte");
   chk_sof_delay: assert property (fifoSof |-> fifoValid && $past(rxSof, 7))
      else $error("fifo start marker misplaced");
   chk_eof_delay: assert property (fifoEof |-> fifoValid && $past(rxEof, 7))
      else $error("fifo end marker misplaced");
   chk_frame_whole: assert property ($rose(fifoValid) |-> fifoSof)
      else $error("frame written without its first byte");
   chk_bad_on_eof: assert property (fifoBad |-> fifoEof)
      else $error("bad mark away from frame end");
   chk_desc_hold: assert property (descReq && !descAck |=> descReq)
      else $error("descriptor request dropped unanswered");
   chk_desc_release: assert property (descReq && descAck |=> !descReq)
      else $error("descriptor request held after answer");
   // main traffic seen at all
   cover property (fifoEof);
   cover property (fifoBad);
   cover property (descReq && descAck);
endmodule

bind raf_rx_filter raf_rx_filter_checker chk (
   .clk_sys   (clk_sys),
   .sys_rst   (sys_rst),
   .descReq   (descReq),
   .descAck   (descAck),
   .rxValid   (rxValid),
   .rxSof     (rxSof),
   .rxEof     (rxEof),
   .rxData    (rxData),
   .fifoValid (fifoValid),
   .fifoSof   (fifoSof),
   .fifoEof   (fifoEof),
   .fifoBad   (fifoBad),
   .fifoData  (fifoData)
);

// [dv/raf_desc_model.sv]
// descriptor list owner answering ownership queries
module raf_desc_model #(
   parameter int LAT = 3
) (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic descReq,
   input  wire logic hostOwns,
   output logic      descAck,
   output logic      descOwn
);
   timeunit 1ns;
   timeprecision 1ps;
   int waitCnt;
   // answer LAT+1 cycles after the request rises; ownership toggles outside the answer so it is never trusted
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         descAck <= 1'b0;
         descOwn <= 1'b0;
         waitCnt <= 0;
      end else if (descReq && !descAck && waitCnt == LAT) begin
         descAck <= 1'b1;
         descOwn <= !hostOwns;
         waitCnt <= 0;
      end else begin
         descAck <= 1'b0;
         descOwn <= ~descOwn;
         waitCnt <= (descReq && !descAck) ? waitCnt + 1 : 0;
      end
   end
endmodule

// [dv/tb_raf_rx_filter.sv]
// self-checking testbench for the receive filter
`include "raf_rx_filter_defs.vh"
module tb_raf_rx_filter;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [47:0] DA_A = 48'h0000_5544_3322;
   localparam logic [47:0] DA_B = 48'h0000_5544_3324;
   localparam logic [47:0] DA_M = 48'h0000_5E00_0001;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel = 1'b0, hwrite = 1'b0, hostOwns = 1'b0;
   logic [7:0]  haddr = 8'h00, rxData = 8'h00, setupAddrIdx = 8'h00;
   logic [1:0]  htrans = 2'h0, setupFilterType = 2'h0;
   logic [31:0] hwdata = 32'h0, rdData;
   logic        setupTypeWe = 1'b0, setupAddrWe = 1'b0, setupHashWe = 1'b0;
   logic [47:0] setupAddr = 48'h0;
   logic [4:0]  setupHashIdx = 5'h00;
   logic [15:0] setupHashWord = 16'h0000;
   logic        rxValid = 1'b0, rxSof = 1'b0, rxEof = 1'b0, rxErr = 1'b0;
   wire  [31:0] hrdata;
   wire  [7:0]  fifoData;
   wire         hreadyout, hresp, irq, descReq, descAck, descOwn;
   wire         fifoValid, fifoSof, fifoEof, fifoBad;
   int          err_total = 0, cmp_count = 0, rxBytes = 0, cycles = 0, badCnt = 0;

   always #2 clk_sys = ~clk_sys;

   raf_rx_filter dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
      .setupTypeWe(setupTypeWe), .setupFilterType(setupFilterType), .setupAddrWe(setupAddrWe),
      .setupAddrIdx(setupAddrIdx[3:0]), .setupAddr(setupAddr), .setupHashWe(setupHashWe),
      .setupHashIdx(setupHashIdx), .setupHashWord(setupHashWord), .descReq(descReq),
      .descAck(descAck), .descOwn(descOwn), .rxValid(rxValid), .rxSof(rxSof), .rxEof(rxEof),
      .rxData(rxData), .rxErr(rxErr), .fifoValid(fifoValid), .fifoSof(fifoSof),
      .fifoEof(fifoEof), .fifoBad(fifoBad), .fifoData(fifoData));

   raf_desc_model #(.LAT(3)) host (.clk_sys(clk_sys), .sys_rst(sys_rst), .descReq(descReq),
      .hostOwns(hostOwns), .descAck(descAck), .descOwn(descOwn));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // count fifo bytes and cut a hang short
   always @(posedge clk_sys) begin
      cycles++;
      if (fifoValid === 1'b1) rxBytes++;
      if (fifoBad === 1'b1) badCnt++;
      if (cycles == 30000) begin
         err_total++;
         results();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         $display("mismatch at %0t ns: %s", $time, what);
         err_total++;
      end
   endtask

   // one single ahb transfer; the wait ends only on hready
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : ~hwdata;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rdData = hrdata;
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      check(rdData & m, e, "register read");
      check(hresp, 1'b0, "okay response");
   endtask

   // frame with no gaps, then idle long enough to drain the pipe
   task automatic frm(input logic [47:0] da, input int len, input logic er, input int exp);
      int base;
      base = rxBytes;
      for (int i = 0; i < len; i++) begin
         @(posedge clk_sys);
         rxValid <= 1'b1;
         rxSof <= (i == 0);
         rxEof <= (i == len - 1);
         rxErr <= er;
         rxData <= (i < 6) ? da[8*i +: 8] : i[7:0];
      end
      @(posedge clk_sys);
      rxValid <= 1'b0;
      rxEof <= 1'b0;
      rxData <= ~rxData;
      repeat (14) @(posedge clk_sys);
      check(rxBytes - base, exp, "frame byte count");
   endtask

   task automatic setType(input logic [1:0] t);
      @(posedge clk_sys);
      setupTypeWe <= 1'b1;
      setupFilterType <= t;
      @(posedge clk_sys);
      setupTypeWe <= 1'b0;
   endtask

   // whole hash table to one value: all-ones passes every hashed address
   task automatic setHash(input logic [15:0] w);
      for (int k = 0; k < 32; k++) begin
         @(posedge clk_sys);
         setupHashWe <= 1'b1;
         setupHashIdx <= k[4:0];
         setupHashWord <= w;
      end
      @(posedge clk_sys);
      setupHashWe <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rdChk(`RAF_OFS_OPMODE, 32'hFFFF_FFFF, 32'h0);
      rdChk(`RAF_OFS_STATUS, 32'h0006_0000, 32'h0);
      rdChk(8'h20, 32'hFFFF_FFFF, 32'h0);
      bus(`RAF_OFS_OPMODE, 1'b1, 32'hFF);
      rdChk(`RAF_OFS_OPMODE, 32'hFF, 32'hCA);
      bus(`RAF_OFS_OPMODE, 1'b1, 32'h0);
      @(posedge clk_sys);
      setupAddrWe <= 1'b1;
      setupAddr <= DA_A;
      @(posedge clk_sys);
      setupAddrWe <= 1'b0;
      frm(DA_A, 20, 1'b0, 0);
      $display("test registers and idle done");
      hostOwns <= 1'b1;
      bus(`RAF_OFS_OPMODE, 1'b1, 32'h2);
      repeat (12) @(posedge clk_sys);
      rdChk(`RAF_OFS_STATUS, 32'h0006_0080, 32'h0004_0080);
      check(irq, 1'b0, "irq while masked");
      bus(`RAF_OFS_INTEN, 1'b1, 32'h80);
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b1, "irq raised");
      bus(`RAF_OFS_INTCLR, 1'b1, 32'h80);
      repeat (2) @(posedge clk_sys);
      check(irq, 1'b0, "irq cleared");
      hostOwns <= 1'b0;
      bus(`RAF_OFS_POLL, 1'b1, 32'h0);
      repeat (12) @(posedge clk_sys);
      rdChk(`RAF_OFS_STATUS, 32'h0006_0000, 32'h0002_0000);
      $display("test start and suspend done");
      frm(DA_A, 20, 1'b0, 20);
      frm(DA_B, 20, 1'b0, 0);
      setType(`RAF_FT_INVERSE);
      rdChk(`RAF_OFS_OPMODE, 32'h1F, 32'h12);
      frm(DA_A, 20, 1'b0, 0);
      frm(DA_B, 20, 1'b0, 20);
      setHash(16'hFFFF);
      setType(`RAF_FT_HASH);
      rdChk(`RAF_OFS_OPMODE, 32'h1F, 32'h03);
      frm(DA_M, 20, 1'b0, 20);
      frm(DA_B, 20, 1'b0, 0);
      frm(DA_A, 20, 1'b0, 20);
      setHash(16'h0000);
      frm(DA_M, 20, 1'b0, 0);
      setHash(16'hFFFF);
      setType(`RAF_FT_HASH_ONLY);
      frm(DA_B, 20, 1'b0, 20);
      setHash(16'h0000);
      frm(DA_A, 20, 1'b0, 0);
      $display("test filtering modes done");
      setType(`RAF_FT_PERFECT);
      bus(`RAF_OFS_OPMODE, 1'b1, 32'h42);
      frm(DA_B, 20, 1'b0, 20);
      bus(`RAF_OFS_OPMODE, 1'b1, 32'h82);
      frm(DA_M, 20, 1'b0, 20);
      frm(DA_B, 20, 1'b0, 0);
      bus(`RAF_OFS_OPMODE, 1'b1, 32'h2);
      frm(DA_A, 3, 1'b0, 0);
      bus(`RAF_OFS_OPMODE, 1'b1, 32'hA);
      frm(DA_A, 3, 1'b0, 3);
      frm(DA_A, 20, 1'b1, 20);
      check(badCnt, 0, "bad mark despite pass-bad");
      bus(`RAF_OFS_OPMODE, 1'b1, 32'h2);
      frm(DA_A, 20, 1'b1, 20);
      check(badCnt, 1, "bad mark missing");
      $display("test overrides and bad frames done");
      // stopped flag is sticky from the first stop: clear it so the stop is seen anew
      bus(`RAF_OFS_INTCLR, 1'b1, 32'h100);
      fork
         frm(DA_A, 20, 1'b0, 20);
         begin
            repeat (4) @(posedge clk_sys);
            bus(`RAF_OFS_OPMODE, 1'b1, 32'h0);
            rdChk(`RAF_OFS_STATUS, 32'h0006_0100, 32'h0002_0000);
         end
      join
      rdChk(`RAF_OFS_STATUS, 32'h0006_0140, 32'h0000_0140);
      frm(DA_A, 20, 1'b0, 0);
      $display("test stop done");
      results();
   end
endmodule
